// file: core/drv_ctrl_pkg.sv
// Shared constants and types for the driver mode, serial link and gate control logic
package drv_ctrl_pkg;
  // Channel and frame geometry
  localparam int NUM_GD     = 6;
  localparam int FRAME_BITS = 16;
  localparam int FRAME_STEP = 8;
  localparam int PIN_W      = 5 + 3 * NUM_GD;
  // Pulse counter: 16 pulses accepted, then it cycles 16..23 so that 16 + 8n lands on 16 again
  localparam logic [4:0] FRAME_OK_COUNT   = 5'h10;
  localparam logic [4:0] FRAME_WRAP_COUNT = 5'h17;
  localparam logic [4:0] FIRST_PULSE      = 5'h01;
  localparam int SCLK_MAX_KHZ = 4000;
  // Supply dip filter
  localparam int CLOCK_PERIOD_NS   = 20;
  localparam int POR_FILTER_NS     = 500;
  localparam int POR_FILTER_CYCLES = (POR_FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [4:0] POR_LAST  = 5'(POR_FILTER_CYCLES - 1);
  // Command word fields
  localparam int OP_LSB    = 11;
  localparam int GD_ON_LSB = 0;
  localparam int MEAS_LSB  = 6;
  localparam int MEAS_W    = 4;
  localparam logic [4:0] OP_GD_ONOFF   = 5'h08;
  localparam logic [4:0] OP_PWM_PIN_EN = 5'h0a;
  localparam logic [4:0] OP_AND_OR     = 5'h0b;
  // Response word layout
  localparam int RESP_SHORT_LSB = 0;
  localparam int RESP_OPEN_LSB  = 8;
  // Values after power-on reset
  localparam logic [5:0] GD_ONOFF_RESET = 6'h00;
  localparam logic [5:0] PWM_DIS_RESET  = 6'h00;
  localparam logic [5:0] AND_OR_RESET   = 6'h00;
  localparam logic [3:0] MEAS_RESET     = 4'h0;
  // Device modes and response content kinds
  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FALLBACK} mode_t;
  typedef enum logic {RESP_STATUS, RESP_CONFIG} resp_kind_t;
endpackage

// file: core/spi_link.sv
// Serial link front end running on the serial clock
`timescale 1ns/100ps
`default_nettype none
module spi_link import drv_ctrl_pkg::*; (
  // Link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so_out,
  output logic             so_oe,
  // Words exchanged with the control domain
  input  wire logic [15:0] resp_word,
  output logic [15:0]      rx_word,
  output logic             frame_ok
);
  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] sh;
  } link_t;

  link_t st;
  link_t next_st;
  logic  armed;
  logic  had_pulse;
  logic  shifting;
  logic  so_q;

  // One shift register carries the response out and the command in, so after 16 pulses
  // the received word follows on the output: this gives the echo and daisy chaining
  always_comb begin
    next_st = st;
    if (armed) begin
      next_st.cnt = FIRST_PULSE;
      next_st.sh  = {resp_word[14:0], si}; // RULE10
    end else begin
      next_st.sh  = {st.sh[14:0], si}; // RULE12
      next_st.cnt = (st.cnt == FRAME_WRAP_COUNT) ? FRAME_OK_COUNT : st.cnt + FIRST_PULSE;
    end
  end

  // Input sampled on the rising edge, most significant bit first
  always_ff @(posedge sclk) begin
    st <= next_st; // RULE21
  end

  // Armed is set while deselected; the link clock stands still outside frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  // Captured at chip select rise: a frame with no pulse keeps the old count and word,
  // so without this flag an empty select would run the previous command again
  always_ff @(posedge cs_n) begin
    had_pulse <= ~armed; // RULE11
  end

  // Output changes only on falling edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shifting <= 1'b0;
    end else begin
      shifting <= 1'b1;
    end
  end

  always_ff @(negedge sclk) begin
    so_q <= st.sh[15]; // RULE21
  end

  // Words stay still once the frame ends, until the next frame's first edge
  assign so_out   = shifting ? so_q : resp_word[15];
  assign so_oe    = ~cs_n; // RULE22
  assign rx_word  = st.sh;
  // Armed rises as chip select rises, so it cannot qualify the word that the control side reads later
  assign frame_ok = had_pulse & (st.cnt == FRAME_OK_COUNT); // RULE9 RULE11
endmodule
`default_nettype wire

// file: core/driver_mode_spi_gate_control.sv
// Mode control, command execution, gate drive and fault reporting of the output driver
// How it works
// RULE1: Enable or supply low puts the device to sleep with every output off. The code leaves the measurement select outputs at their stored values in sleep.
// RULE2: Powered and enabled: fallback pin low gives normal, high gives fallback mode.
// RULE3: Leaving sleep for normal mode returns every register to its reset value.
// RULE4: Fallback to normal keeps all registers; outputs follow stored settings again.
// RULE5: Reset values: outputs off, pins enabled and ORed, regulators and switches off. The code enables the switch and regulator outputs in normal mode.
// RULE6: Supply dips shorter than 0.5 us are ignored and state is kept.
// RULE7: Fallback disables switch and regulator outputs; gates follow their pin only. The code still holds the measured pair off in fallback.
// RULE8: Fallback keeps all control and fault bits; exit restores stored output control.
// RULE9: Frames are 16 bits; serial clock up to 4 MHz.
// RULE10: Response shifted out is chosen by the previously received command.
// RULE11: Only 16 plus a multiple of 8 pulses is accepted; others are discarded.
// RULE12: First 16 bits return fault status; the next 16 echo the host word.
// RULE13: In a 32-bit transfer the last 16-bit word executes at chip select rise.
// RULE14: Two chained devices need 32 clocks per transfer, issued by the host.
// RULE15: An off gate with drain below 2.5 V flags an open-load fault.
// RULE16: An on gate with drain above threshold past the filter time flags a short.
// RULE17: Bits 0 to 5 turn gates one to six on; zero pulls the gate low.
// RULE18: Bits 6 to 9 select a measured pair, which is disabled; others run on.
// RULE19: Codes 1-6 pair 1-2, 3-4, 5-6; codes 10-14 pair with one; rest normal.
// RULE20: Status bits read zero for healthy drivers and one for faulted ones.
// RULE21: Input latched on rising clock, output changed on falling, MSB first.
// RULE22: Command acts only at chip select rise, which also floats the output.
// RULE23: Measurement select is zero after reset so every gate runs normally.
`timescale 1ns/100ps
`default_nettype none
module driver_mode_spi_gate_control import drv_ctrl_pkg::*; #(
  parameter int SHORT_FILTER_CYCLES = 16,
  parameter int FILT_W              = 8
) (
  // System clock and control
  input  wire logic              clock,
  input  wire logic              clock_en,
  input  wire logic              srst,
  // Supply monitors and mode pins
  input  wire logic              battery_supply_ok,
  input  wire logic              logic_supply_ok,
  input  wire logic              enable,
  input  wire logic              fallback,
  // Serial link
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              si,
  output logic                   so_out,
  output logic                   so_oe,
  // Gate drivers and drain comparators
  input  wire logic [NUM_GD-1:0] gate_pwm_inputs,
  input  wire logic [NUM_GD-1:0] drain_open_low,
  input  wire logic [NUM_GD-1:0] drain_short_high,
  output logic [NUM_GD-1:0]      gate_drive_out,
  // Load resistance measurement mux
  output logic                   meas_active,
  output logic [2:0]             meas_reference_resistor_pin_ch,
  output logic [2:0]             meas_amp_ch,
  // Other output blocks and mode
  output logic                   octal_low_side_switch_en,
  output logic                   current_regulator_en,
  output logic                   sleep_active
);
  localparam logic [FILT_W-1:0] SHORT_LAST = FILT_W'(SHORT_FILTER_CYCLES - 1);

  typedef struct packed {
    mode_t                         mode;
    logic [PIN_W-1:0]              pin_s1;
    logic [PIN_W-1:0]              pin_s2;
    logic                          cs_prev;
    logic                          pwr_good;
    logic [4:0]                    low_cnt;
    logic [5:0]                    gd_onoff;
    logic [5:0]                    pwm_dis;
    logic [5:0]                    and_or;
    logic [3:0]                    meas;
    logic [5:0]                    open_flt;
    logic [5:0]                    short_flt;
    logic [NUM_GD-1:0][FILT_W-1:0] short_cnt;
    resp_kind_t                    kind;
    logic [15:0]                   resp;
    logic [5:0]                    gate;
  } ctrl_t;

  ctrl_t             st;
  ctrl_t             next_st;
  logic [15:0]       rx_word;
  logic              frame_ok;
  logic              cs_s;
  logic              fb_s;
  logic              en_s;
  logic              vdd_s;
  logic              battery_supply_s;
  logic [NUM_GD-1:0] pwm_s;
  logic [NUM_GD-1:0] open_s;
  logic [NUM_GD-1:0] short_s;
  logic              frame_edge;
  logic              cmd_exec;
  logic [4:0]        opcode;
  logic [5:0]        meas_sel;
  logic [NUM_GD-1:0] meas_mask;
  logic [NUM_GD-1:0] gate_want;

  // Link-side logic on the serial clock
  spi_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .si        (si),
    .so_out    (so_out),
    .so_oe     (so_oe),
    .resp_word (st.resp),
    .rx_word   (rx_word),
    .frame_ok  (frame_ok)
  );

  // Register contents after power-on reset
  function automatic ctrl_t por_state(input ctrl_t s);
    ctrl_t r;
    r           = s;
    r.gd_onoff  = GD_ONOFF_RESET; // RULE5
    r.pwm_dis   = PWM_DIS_RESET; // RULE5
    r.and_or    = AND_OR_RESET; // RULE5
    r.meas      = MEAS_RESET; // RULE23
    r.open_flt  = '0;
    r.short_flt = '0;
    r.short_cnt = '0;
    r.kind      = RESP_STATUS; // RULE12
    r.gate      = '0;
    return r;
  endfunction

  // Measurement select decode to {current channel, amplifier channel}
  function automatic logic [5:0] meas_decode(input logic [3:0] code);
    case (code) // RULE19
      4'h1:    meas_decode = {3'h1, 3'h2};
      4'h2:    meas_decode = {3'h2, 3'h1};
      4'h3:    meas_decode = {3'h3, 3'h4};
      4'h4:    meas_decode = {3'h4, 3'h3};
      4'h5:    meas_decode = {3'h5, 3'h6};
      4'h6:    meas_decode = {3'h6, 3'h5};
      4'ha:    meas_decode = {3'h2, 3'h1};
      4'hb:    meas_decode = {3'h3, 3'h1};
      4'hc:    meas_decode = {3'h4, 3'h1};
      4'hd:    meas_decode = {3'h5, 3'h1};
      4'he:    meas_decode = {3'h6, 3'h1};
      default: meas_decode = 6'h00;
    endcase
  endfunction

  // Synchronised pin views; only the second stage is read
  assign {cs_s, fb_s, en_s, vdd_s, battery_supply_s, pwm_s, open_s, short_s} = st.pin_s2;
  assign frame_edge = cs_s & ~st.cs_prev;
  // Link words are quiet by now: no serial clock while chip select is high
  assign cmd_exec   = clock_en & frame_edge & frame_ok & (st.mode != MODE_SLEEP); // RULE22 RULE11 RULE13
  assign opcode     = rx_word[OP_LSB +: 5];
  assign meas_sel   = meas_decode(st.meas);

  // Per-gate output selection
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GD; gi++) begin : g_gate
      logic pin_ctrl;
      assign meas_mask[gi] = (meas_sel[5:3] == 3'(gi + 1)) | (meas_sel[2:0] == 3'(gi + 1)); // RULE18
      // Enabled pin is ORed or ANDed with the stored bit; a disabled pin leaves the bit alone
      assign pin_ctrl = st.pwm_dis[gi] ? st.gd_onoff[gi] :
                        st.and_or[gi] ? (pwm_s[gi] & st.gd_onoff[gi]) : (pwm_s[gi] | st.gd_onoff[gi]); // RULE17
      assign gate_want[gi] = ~meas_mask[gi] &
                             ((st.mode == MODE_NORMAL) ? pin_ctrl : // RULE4 RULE8
                              (st.mode == MODE_FALLBACK) ? pwm_s[gi] : 1'b0); // RULE7 RULE1
    end
  endgenerate

  // Next-state logic; everything holds while the clock enable is low
  always_comb begin
    next_st = st;
    if (clock_en) begin
      next_st.pin_s1  = {cs_n, fallback, enable, logic_supply_ok, battery_supply_ok,
                         gate_pwm_inputs, drain_open_low, drain_short_high};
      next_st.pin_s2  = st.pin_s1;
      next_st.cs_prev = cs_s;
      // Short supply dips are filtered so internal state survives transients
      if (battery_supply_s & vdd_s) begin
        next_st.low_cnt  = 5'h00;
        next_st.pwr_good = 1'b1;
      end else if (st.low_cnt == POR_LAST) begin
        next_st.pwr_good = 1'b0; // RULE6
      end else begin
        next_st.low_cnt = st.low_cnt + 5'h01;
      end
      // Mode selection
      case ({st.pwr_good & en_s, fb_s})
        2'b10:   next_st.mode = MODE_NORMAL; // RULE2
        2'b11:   next_st.mode = MODE_FALLBACK; // RULE2
        default: next_st.mode = MODE_SLEEP; // RULE1
      endcase
      // Commands are stored in fallback too; the measurement select acts at once, the rest once normal mode returns
      if (cmd_exec) begin
        case (opcode)
          OP_GD_ONOFF: begin
            next_st.gd_onoff = rx_word[GD_ON_LSB +: NUM_GD]; // RULE17
            next_st.meas     = rx_word[MEAS_LSB +: MEAS_W]; // RULE18
          end
          OP_PWM_PIN_EN: next_st.pwm_dis = rx_word[5:0];
          OP_AND_OR:     next_st.and_or = rx_word[5:0];
          default:       ;
        endcase
        next_st.kind = (opcode == OP_PWM_PIN_EN || opcode == OP_AND_OR) ? RESP_CONFIG : RESP_STATUS; // RULE10
      end
      // Fault detection; a new fault wins over clearing of a reported one
      for (int i = 0; i < NUM_GD; i++) begin
        if (st.mode != MODE_SLEEP && st.gate[i] && short_s[i]) begin
          if (st.short_cnt[i] != SHORT_LAST) begin
            next_st.short_cnt[i] = st.short_cnt[i] + FILT_W'(1);
          end
        end else begin
          next_st.short_cnt[i] = '0;
        end
        if (cmd_exec && st.kind == RESP_STATUS) begin
          next_st.open_flt[i]  = st.open_flt[i] & ~st.resp[RESP_OPEN_LSB + i];
          next_st.short_flt[i] = st.short_flt[i] & ~st.resp[RESP_SHORT_LSB + i];
        end
        if (st.mode != MODE_SLEEP && !st.gate[i] && open_s[i]) begin
          next_st.open_flt[i] = 1'b1; // RULE15
        end
        if (st.mode != MODE_SLEEP && st.gate[i] && short_s[i] && st.short_cnt[i] == SHORT_LAST) begin
          next_st.short_flt[i] = 1'b1; // RULE16
        end
      end
      // Response refreshed only while deselected, so it stands still through a frame
      if (cs_s && st.cs_prev) begin
        next_st.resp = (st.kind == RESP_STATUS) ? {2'b00, st.open_flt, 2'b00, st.short_flt} : // RULE20
                                                  {2'b00, st.pwm_dis, 2'b00, st.and_or};
      end
      next_st.gate = gate_want;
      // Waking from sleep is a power-on reset
      if (st.mode == MODE_SLEEP && next_st.mode != MODE_SLEEP) begin
        next_st = por_state(next_st); // RULE3
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      st <= por_state('0); // RULE5
    end else begin
      st <= next_st;
    end
  end

  // Outputs decoded from registered state
  assign gate_drive_out           = st.gate;
  assign meas_active              = (meas_sel != 6'h00);
  assign meas_reference_resistor_pin_ch             = meas_sel[5:3];
  assign meas_amp_ch              = meas_sel[2:0];
  assign octal_low_side_switch_en = (st.mode == MODE_NORMAL); // RULE7
  assign current_regulator_en     = (st.mode == MODE_NORMAL); // RULE7
  assign sleep_active             = (st.mode == MODE_SLEEP); // RULE1

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_sleep_off;
    (clock_en && st.mode == MODE_SLEEP) |-> (!octal_low_side_switch_en && !current_regulator_en) ##1
      (gate_drive_out == 6'h00);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("gate on in sleep"); // RULE1

  property p_mode_sel;
    (clock_en && st.pwr_good && en_s) |=> (st.mode == ($past(fb_s) ? MODE_FALLBACK : MODE_NORMAL));
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("wrong mode"); // RULE2

  property p_wake_reset;
    (clock_en && st.mode == MODE_SLEEP && next_st.mode != MODE_SLEEP) |=>
      (st.gd_onoff == GD_ONOFF_RESET) && (st.meas == MEAS_RESET) && (st.open_flt == 6'h00);
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("no reset on wake"); // RULE3

  property p_fb_keep;
    (clock_en && st.mode == MODE_FALLBACK && next_st.mode == MODE_NORMAL && !cmd_exec) |=>
      $stable(st.gd_onoff) && $stable(st.pwm_dis) && $stable(st.and_or);
  endproperty
  a_fb_keep: assert property (p_fb_keep) else $error("registers lost leaving fallback"); // RULE4

  property p_dip;
    (clock_en && st.pwr_good && st.low_cnt != POR_LAST) |=> st.pwr_good;
  endproperty
  a_dip: assert property (p_dip) else $error("short dip caused reset"); // RULE6

  property p_fb_pins;
    (clock_en && st.mode == MODE_FALLBACK && fb_s && st.meas == MEAS_RESET) |=>
      (gate_drive_out == $past(pwm_s)) && !current_regulator_en;
  endproperty
  a_fb_pins: assert property (p_fb_pins) else $error("fallback gate not following pins"); // RULE7

  property p_bad_frame;
    (clock_en && frame_edge && !frame_ok) |=> $stable(st.gd_onoff) && $stable(st.meas);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame executed"); // RULE11

  property p_gd_write;
    (cmd_exec && opcode == OP_GD_ONOFF) |=> (st.gd_onoff == $past(rx_word[5:0])) ##1 (st.meas != 4'h0 || st.gate == $past(gate_want));
  endproperty
  a_gd_write: assert property (p_gd_write) else $error("gate command not stored"); // RULE17

  property p_meas_map;
    (st.meas == 4'hb) |-> (meas_reference_resistor_pin_ch == 3'h3) && (meas_amp_ch == 3'h1) && !gate_want[2] && !gate_want[0];
  endproperty
  a_meas_map: assert property (p_meas_map) else $error("measure pair wrong"); // RULE18

  property p_open;
    (clock_en && st.mode != MODE_SLEEP && !st.gate[0] && open_s[0]) |=> st.open_flt[0];
  endproperty
  a_open: assert property (p_open) else $error("open load not flagged"); // RULE15

  c_frame: cover property (cmd_exec && opcode == OP_GD_ONOFF);
  c_fallback: cover property (st.mode == MODE_FALLBACK ##1 st.mode == MODE_NORMAL);
  c_measure: cover property (meas_active && gate_drive_out != 6'h00);
  c_short: cover property (st.short_flt != 6'h00);
endmodule
`default_nettype wire

// file: verif/spi_host_model.sv
// Host-side serial master model that drives the link pins of the driver block
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out
);
  // Idle: deselected with the clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // One frame of n pulses. The clock runs only inside the frame, and select moves only while it is low
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    #31 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #62.5 sclk = 1'b1;
      rx = {rx[30:0], so_out};
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si; // Deselected: show the inverse so a stale value is never mistaken for data
    #250; // Gap well above the synchroniser and refresh time between frames
  endtask
endmodule
`default_nettype wire

// file: verif/driver_mode_spi_gate_control_bench.sv
// Self-checking bench for the driver mode, serial command and gate control block
`timescale 1ns/100ps
`default_nettype none
module driver_mode_spi_gate_control_bench import drv_ctrl_pkg::*;;
  logic        clock;
  logic        clock_en;
  logic        srst;
  logic        battery_supply_ok;
  logic        logic_supply_ok;
  logic        enable;
  logic        fallback;
  logic [5:0]  gate_pwm_inputs;
  logic [5:0]  drain_open_low;
  logic [5:0]  drain_short_high;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic   si;
  wire logic   so_out;
  wire logic   so_oe;
  wire logic [5:0] gate_drive_out;
  wire logic   meas_active;
  wire logic [2:0] meas_reference_resistor_pin_ch;
  wire logic [2:0] meas_amp_ch;
  wire logic   octal_low_side_switch_en;
  wire logic   current_regulator_en;
  wire logic   sleep_active;
  logic [31:0] rx_last;
  int          n_fail;
  int          checked;

  driver_mode_spi_gate_control #(.SHORT_FILTER_CYCLES(2), .FILT_W(8)) dut (
    .clock(clock), .clock_en(clock_en), .srst(srst),
    .battery_supply_ok(battery_supply_ok), .logic_supply_ok(logic_supply_ok),
    .enable(enable), .fallback(fallback), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe), .gate_pwm_inputs(gate_pwm_inputs),
    .drain_open_low(drain_open_low), .drain_short_high(drain_short_high),
    .gate_drive_out(gate_drive_out), .meas_active(meas_active),
    .meas_reference_resistor_pin_ch(meas_reference_resistor_pin_ch), .meas_amp_ch(meas_amp_ch),
    .octal_low_side_switch_en(octal_low_side_switch_en),
    .current_regulator_en(current_regulator_en), .sleep_active(sleep_active)
  );

  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out));

  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail = n_fail + 1;
    end
  endtask

  // Covers synchroniser, execution and the registered gate stage with margin
  task automatic settle();
    repeat (12) @(posedge clock);
  endtask

  task automatic cmd(input logic [15:0] w);
    host.xfer({16'h0, w}, 16, rx_last);
    settle();
  endtask

  task automatic tally_and_finish();
    $display("TB: checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset state, mode entry and pins ORed by default
  task automatic t_reset();
    chk("sleep in reset", 1, sleep_active);
    chk("gates in reset", 0, gate_drive_out);
    srst <= 1'b0;
    settle();
    chk("sleep left", 0, sleep_active);
    chk("switch enable", 1, octal_low_side_switch_en);
    chk("meas after reset", 0, {meas_active, meas_reference_resistor_pin_ch, meas_amp_ch});
    // Clock enable low must freeze the pin path and the gate stage
    @(posedge clock) begin
      clock_en        <= 1'b0;
      gate_pwm_inputs <= 6'h09;
    end
    settle();
    chk("frozen by clock enable", 0, gate_drive_out);
    clock_en <= 1'b1;
    settle();
    chk("pins ORed", 6'h09, gate_drive_out);
    @(posedge clock) gate_pwm_inputs <= 6'h00;
    settle();
  endtask

  // Status then echo; the second word executes
  task automatic t_integrity();
    host.xfer(32'h4015402a, 32, rx_last);
    settle();
    chk("status word", 16'h0000, rx_last[31:16]);
    chk("echo word", 16'h4015, rx_last[15:0]);
    chk("second word", 6'h2a, gate_drive_out);
    chk("so released", 0, so_oe);
  endtask

  // Pulse counts other than 16+8n leave the registers alone
  task automatic t_count();
    host.xfer(32'h0000403f, 17, rx_last);
    host.xfer(32'h0000403f, 20, rx_last);
    settle();
    chk("odd count", 6'h2a, gate_drive_out);
    host.xfer(32'h00004015, 24, rx_last);
    settle();
    chk("24 pulses", 6'h15, gate_drive_out);
  endtask

  // Every measurement select code with all gates on
  task automatic t_meas();
    logic [2:0] r;
    logic [2:0] a;
    logic [5:0] g;
    for (int c = 0; c < 16; c++) begin
      r = 3'h0;
      a = 3'h0;
      if (c >= 1 && c <= 6) begin
        r = 3'(c);
        a = (c % 2 == 1) ? 3'(c + 1) : 3'(c - 1);
      end else if (c >= 10 && c <= 14) begin
        r = 3'(c - 8);
        a = 3'h1;
      end
      g = 6'h3f;
      if (r != 3'h0) begin
        g[r - 1] = 1'b0;
        g[a - 1] = 1'b0;
      end
      cmd(16'h403f | 16'(c << 6));
      chk("meas reference_resistor_pin", r, meas_reference_resistor_pin_ch);
      chk("meas amp", a, meas_amp_ch);
      chk("meas active", r != 3'h0, meas_active);
      chk("meas gates", g, gate_drive_out);
    end
  endtask

  // Open and short faults, then the response chosen by the previous command
  task automatic t_faults();
    cmd(16'h4000);
    @(posedge clock) drain_open_low <= 6'h05;
    repeat (10) @(posedge clock);
    drain_open_low <= 6'h00;
    cmd(16'h4001);
    chk("open status", 16'h0500, rx_last[15:0]);
    @(posedge clock) drain_short_high <= 6'h01;
    repeat (10) @(posedge clock);
    drain_short_high <= 6'h00;
    cmd(16'h0000);
    chk("short status", 16'h0001, rx_last[15:0]);
    cmd(16'h5001);
    cmd(16'h5000);
    chk("config response", 16'h0100, rx_last[15:0]);
  endtask

  // Fallback follows pins only and returns to stored settings
  task automatic t_fallback();
    cmd(16'h4007);
    @(posedge clock) gate_pwm_inputs <= 6'h30;
    settle();
    chk("normal OR", 6'h37, gate_drive_out);
    fallback <= 1'b1;
    settle();
    chk("fallback gates", 6'h30, gate_drive_out);
    chk("fallback outputs", 0, {octal_low_side_switch_en, current_regulator_en});
    chk("fallback awake", 0, sleep_active);
    fallback <= 1'b0;
    settle();
    chk("restored gates", 6'h37, gate_drive_out);
    chk("restored outputs", 2'h3, {octal_low_side_switch_en, current_regulator_en});
    cmd(16'h5830);
    chk("pins ANDed", 6'h07, gate_drive_out);
    cmd(16'h4007);
    @(posedge clock) gate_pwm_inputs <= 6'h00;
  endtask

  // Supply dip filter, sleep entry and reset on wake
  task automatic t_sleep();
    @(posedge clock) logic_supply_ok <= 1'b0;
    repeat (10) @(posedge clock);
    logic_supply_ok <= 1'b1;
    settle();
    chk("short dip", 7'h07, {sleep_active, gate_drive_out});
    enable <= 1'b0;
    settle();
    chk("sleep by enable", 7'h40, {sleep_active, gate_drive_out});
    chk("sleep outputs", 0, {octal_low_side_switch_en, current_regulator_en});
    enable <= 1'b1;
    settle();
    chk("wake reset", 7'h00, {sleep_active, gate_drive_out});
    // A select with no pulse must not replay the last gate word
    host.xfer(32'h0, 0, rx_last);
    settle();
    chk("empty frame", 0, gate_drive_out);
    battery_supply_ok <= 1'b0;
    repeat (40) @(posedge clock);
    chk("long drop", 1, sleep_active);
    battery_supply_ok <= 1'b1;
    settle();
  endtask

  // Hang guard, well beyond the hundred or so microseconds the tests need
  initial begin
    #400000;
    n_fail = n_fail + 1;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    clock_en = 1'b1;
    srst = 1'b1;
    battery_supply_ok = 1'b1;
    logic_supply_ok = 1'b1;
    enable = 1'b1;
    fallback = 1'b0;
    gate_pwm_inputs = 6'h00;
    drain_open_low = 6'h00;
    drain_short_high = 6'h00;
    repeat (4) @(posedge clock);
    t_reset();
    t_integrity();
    t_count();
    t_meas();
    t_faults();
    t_fallback();
    t_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
